// File: src/cdw_generator.sv
// complementary waveform generator with dead band and auto-shutdown
`timescale 1ns/10ps
`default_nettype none
module cdw_generator #(
    parameter int DB_WIDTH = cdw_pkg::DB_W
)(
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic [cdw_pkg::PWM_CH-1:0]  pulse_channel,
    input  wire logic                        numeric_oscillator_output,
    input  wire logic                        logic_cell1_output,
    input  wire logic                        logic_cell2_output,
    input  wire logic                        fault_input_pin,
    input  wire logic                        module_enable_bit,
    input  wire logic                        output_a_enable,
    input  wire logic                        output_b_enable,
    input  wire logic                        output_a_polarity,
    input  wire logic                        output_b_polarity,
    input  wire logic                        clock_source_bit,
    input  wire logic [cdw_pkg::SEL_W-1:0]   input_source_select,
    input  wire logic [DB_WIDTH-1:0]         rising_deadband_register,
    input  wire logic [DB_WIDTH-1:0]         falling_deadband_register,
    input  wire logic                        shutdown_event_set,
    input  wire logic                        shutdown_event_clear,
    input  wire logic                        auto_restart_enable,
    input  wire logic                        shutdown_source_select_0,
    input  wire logic                        shutdown_source_select_1,
    input  wire logic [cdw_pkg::OVR_W-1:0]   override_level_a,
    input  wire logic [cdw_pkg::OVR_W-1:0]   override_level_b,
    output logic                             output_a,
    output logic                             output_a_oe_n,
    output logic                             output_b,
    output logic                             output_b_oe_n,
    output logic                             shutdown_event_bit,
    output logic                             shutdown_active
);
    import cdw_pkg::*;

    logic [SRC_N-1:0] src_raw;
    logic [SRC_N-1:0] src_s;
    logic             in_s;
    logic             in_d_r;
    logic             in_rise;
    logic             in_fall;
    logic [ACC_W-1:0] acc_r;
    logic [ACC_W-1:0] acc_sum;
    logic             db_tick;
    logic             en_d_r;
    logic             en_rise;
    logic             src_active;
    logic             ase_r;
    logic             ase_clear;
    logic             ase_nxt;
    logic             shut_hold_r;
    logic             shut_nxt;
    logic             run_ok;
    logic             rise_done;
    logic             fall_done;
    logic             drive_a_r;
    logic             drive_b_r;

    // polarity-adjusted level of an active-high drive
    function automatic logic pol_level(input logic raw, input logic pol);
        pol_level = pol ? raw : !raw;
    endfunction

    // pin drive as {oe_n, level}
    function automatic logic [1:0] pin_drive(
        input logic             en,
        input logic             oe,
        input logic             shut,
        input logic [OVR_W-1:0] ovr,
        input logic             pol,
        input logic             raw
    );
        logic [1:0] res;
        res = 2'h2;
        if (!en || !oe) begin
            res = 2'h2;
        end else if (shut) begin
            case (ovr)
                OVR_HIGH:  res = 2'h1;
                OVR_LOW:   res = 2'h0;
                OVR_TRI:   res = 2'h2;
                default:   res = {1'b0, pol_level(1'b0, pol)};
            endcase
        end else begin
            res = {1'b0, pol_level(raw, pol)};
        end
        return res;
    endfunction

    // synchronise every source before selection and edge detection
    assign src_raw = {fault_input_pin, logic_cell2_output,
                      logic_cell1_output, numeric_oscillator_output,
                      pulse_channel};

    cdw_sync #(
        .WIDTH (SRC_N)
    ) u_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .din     (src_raw),
        .dout    (src_s)
    );

    // input source selection
    always_comb begin
        in_s = 1'b0;
        case (input_source_select)
            SEL_LC1:  in_s = src_s[IDX_LC1];
            SEL_NCO:  in_s = src_s[IDX_NCO];
            SEL_PWM4: in_s = src_s[IDX_PWM4];
            SEL_PWM3: in_s = src_s[IDX_PWM3];
            SEL_PWM2: in_s = src_s[IDX_PWM2];
            SEL_PULSE_CHANNEL_ONE: in_s = src_s[IDX_PULSE_CHANNEL_ONE];
            default:  in_s = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            in_d_r <= 1'b0;
        end else begin
            in_d_r <= in_s;
        end
    end

    assign in_rise = in_s && !in_d_r;
    assign in_fall = !in_s && in_d_r;

    // dead-band tick: every cycle, or 16 MHz by fractional accumulation
    assign acc_sum = ACC_W'(acc_r + OSC_STEP);

    assign db_tick = (clock_source_bit == CLKSRC_OSC) ?
                     (acc_sum >= SYS_STEP) : 1'b1;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= '0;
        end else if (clock_source_bit != CLKSRC_OSC) begin
            acc_r <= '0;
        end else if (db_tick) begin
            acc_r <= ACC_W'(acc_sum - SYS_STEP);
        end else begin
            acc_r <= acc_sum;
        end
    end

    // module enable edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= module_enable_bit;
        end
    end

    assign en_rise = module_enable_bit && !en_d_r;

    // shutdown event bit: set beats clear
    assign src_active = (shutdown_source_select_0 && src_s[IDX_LC2]) ||
                        (shutdown_source_select_1 && src_s[IDX_FLT]);
    assign ase_clear  = (shutdown_event_clear || auto_restart_enable) &&
                        !src_active;

    assign ase_nxt = shutdown_event_set || src_active ||
                     (ase_r && !ase_clear);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ase_r <= 1'b0;
        end else begin
            ase_r <= ase_nxt;
        end
    end

    // overrides hold until the first rise after the event bit clears
    assign shut_nxt = ase_nxt || (shut_hold_r && !in_rise);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shut_hold_r <= 1'b0;
        end else begin
            shut_hold_r <= shut_nxt;
        end
    end

    assign shutdown_event_bit = ase_r;
    assign shutdown_active    = shut_hold_r;

    // dead-band counters
    assign run_ok = module_enable_bit && !en_rise && !shut_nxt;

    cdw_db_counter #(
        .WIDTH (DB_WIDTH)
    ) u_rise_cnt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (db_tick),
        .start   (run_ok && in_rise),
        .abort   (!run_ok || !in_s),
        .limit   (rising_deadband_register),
        .done    (rise_done)
    );

    cdw_db_counter #(
        .WIDTH (DB_WIDTH)
    ) u_fall_cnt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .tick    (db_tick),
        .start   (run_ok && in_fall),
        .abort   (!run_ok || in_s),
        .limit   (falling_deadband_register),
        .done    (fall_done)
    );

    // active-high drive of output A
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_a_r <= 1'b0;
        end else if (!run_ok) begin
            drive_a_r <= 1'b0;
        end else if (in_fall) begin
            drive_a_r <= 1'b0;
        end else if (rise_done) begin
            drive_a_r <= 1'b1;
        end
    end

    // active-high drive of output B
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_b_r <= 1'b0;
        end else if (!run_ok) begin
            drive_b_r <= 1'b0;
        end else if (in_rise) begin
            drive_b_r <= 1'b0;
        end else if (fall_done) begin
            drive_b_r <= 1'b1;
        end
    end

    // pin A
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_a_oe_n <= 1'b1;
            output_a      <= 1'b0;
        end else begin
            {output_a_oe_n, output_a} <= pin_drive(module_enable_bit,
                output_a_enable, shut_nxt, override_level_a,
                output_a_polarity, drive_a_r);
        end
    end

    // pin B
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_b_oe_n <= 1'b1;
            output_b      <= 1'b0;
        end else begin
            {output_b_oe_n, output_b} <= pin_drive(module_enable_bit,
                output_b_enable, shut_nxt, override_level_b,
                output_b_polarity, drive_b_r);
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_rise_zero;
        run_ok && in_rise && (rising_deadband_register == '0);
    endsequence
    sequence s_fall_zero;
        run_ok && in_fall && (falling_deadband_register == '0);
    endsequence

    a_disabled_no_drive: assert property (
        !module_enable_bit |=> output_a_oe_n && output_b_oe_n)
        else $error("pins driven while the module is disabled");
    a_oe_clear_release: assert property (
        !output_a_enable |=> output_a_oe_n)
        else $error("pin A driven with its output enable clear");
    a_enable_start_clear: assert property (
        $rose(module_enable_bit) |=> !drive_a_r && !drive_b_r)
        else $error("drives not cleared after module enable");
    a_rise_b_off: assert property (
        run_ok && in_rise |=> !drive_b_r)
        else $error("B still on after a rising input edge");
    a_fall_a_off: assert property (
        run_ok && in_fall |=> !drive_a_r)
        else $error("A still on after a falling input edge");
    a_zero_db_rise: assert property (
        s_rise_zero |=> drive_a_r ##1 output_a ==
            pol_level(1'b1, $past(output_a_polarity)) || output_a_oe_n
            || $past(shut_nxt))
        else $error("zero rising dead band did not turn A on at once");
    a_zero_db_fall: assert property (
        s_fall_zero |=> drive_b_r)
        else $error("zero falling dead band did not turn B on at once");
    a_a_needs_high: assert property (
        $rose(drive_a_r) |-> $past(in_s))
        else $error("A turned on after the input had dropped");
    a_no_overlap: assert property (
        !(drive_a_r && drive_b_r))
        else $error("both drives on at once");
    a_polarity_a: assert property (
        module_enable_bit && output_a_enable && !shut_nxt |=>
            !output_a_oe_n &&
            output_a == pol_level($past(drive_a_r), $past(output_a_polarity)))
        else $error("pin A level does not follow drive and polarity");
    a_override_high: assert property (
        module_enable_bit && output_b_enable && shut_nxt &&
        override_level_b == OVR_HIGH |=> output_b && !output_b_oe_n)
        else $error("pin B not forced high in shutdown");
    a_override_tri: assert property (
        module_enable_bit && output_a_enable && shut_nxt &&
        override_level_a == OVR_TRI |=> output_a_oe_n)
        else $error("pin A not released in shutdown");
    a_source_sets: assert property (
        src_active |=> shutdown_event_bit && shutdown_active)
        else $error("active shutdown source did not enter shutdown");
    a_ase_holds: assert property (
        shutdown_event_bit && !auto_restart_enable && !shutdown_event_clear
        |=> shutdown_event_bit)
        else $error("event bit cleared without restart or software clear");
    a_auto_restart: assert property (
        shutdown_event_bit && auto_restart_enable && !src_active &&
        !shutdown_event_set |=> !shutdown_event_bit)
        else $error("auto-restart did not clear the event bit");
    a_hold_till_rise: assert property (
        shutdown_active && !ase_nxt && !in_rise |=> shutdown_active)
        else $error("overrides released before a rising input edge");

endmodule
`default_nettype wire

// File: src/cdw_pkg.sv
// shared constants and types of the complementary waveform generator
`default_nettype none
package cdw_pkg;

    localparam int DB_W      = 6;
    localparam int SEL_W     = 3;
    localparam int OVR_W     = 2;
    localparam int PWM_CH    = 4;
    localparam int SRC_N     = 8;
    localparam int ACC_W     = 7;

    // positions in the synchronised source vector
    localparam int IDX_PULSE_CHANNEL_ONE  = 0;
    localparam int IDX_PWM2  = 1;
    localparam int IDX_PWM3  = 2;
    localparam int IDX_PWM4  = 3;
    localparam int IDX_NCO   = 4;
    localparam int IDX_LC1   = 5;
    localparam int IDX_LC2   = 6;
    localparam int IDX_FLT   = 7;

    // input source select codes
    localparam logic [SEL_W-1:0] SEL_LC1  = 3'h7;
    localparam logic [SEL_W-1:0] SEL_NCO  = 3'h6;
    localparam logic [SEL_W-1:0] SEL_PWM4 = 3'h5;
    localparam logic [SEL_W-1:0] SEL_PWM3 = 3'h4;
    localparam logic [SEL_W-1:0] SEL_PWM2 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_PULSE_CHANNEL_ONE = 3'h2;

    // shutdown override codes
    localparam logic [OVR_W-1:0] OVR_HIGH  = 2'h3;
    localparam logic [OVR_W-1:0] OVR_LOW   = 2'h2;
    localparam logic [OVR_W-1:0] OVR_TRI   = 2'h1;
    localparam logic [OVR_W-1:0] OVR_INACT = 2'h0;

    // dead-band clock source
    localparam logic CLKSRC_OSC = 1'b1;
    localparam int   SYS_CLK_MHZ = 100;
    localparam int   DB_OSC_MHZ  = 16;
    localparam logic [ACC_W-1:0] SYS_STEP = ACC_W'(SYS_CLK_MHZ);
    localparam logic [ACC_W-1:0] OSC_STEP = ACC_W'(DB_OSC_MHZ);

    typedef enum logic {
        CDW_IDLE,
        CDW_COUNT
    } cdw_db_state_t;

endpackage
`default_nettype wire

// File: src/cdw_sync.sv
// two-stage level synchroniser
`timescale 1ns/10ps
`default_nettype none
module cdw_sync #(
    parameter int WIDTH = 8
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    import cdw_pkg::*;

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule
`default_nettype wire

// File: src/cdw_db_counter.sv
// one dead-band counter, counts ticks from zero up to the limit
`timescale 1ns/10ps
`default_nettype none
module cdw_db_counter #(
    parameter int WIDTH = 6
)(
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             tick,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic [WIDTH-1:0] limit,
    output logic                  done
);
    import cdw_pkg::*;

    cdw_db_state_t    state_r;
    logic [WIDTH-1:0] cnt_r;
    logic             zero_lim;
    logic             at_lim;

    assign zero_lim = (limit == '0);
    assign at_lim   = (state_r == CDW_COUNT) && (cnt_r == limit);
    assign done     = (start && zero_lim) || (at_lim && !start && !abort);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= CDW_IDLE;
        end else if (start) begin
            state_r <= zero_lim ? CDW_IDLE : CDW_COUNT;
        end else if (abort || at_lim) begin
            state_r <= CDW_IDLE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (start) begin
            cnt_r <= '0;
        end else if ((state_r == CDW_COUNT) && tick && !at_lim) begin
            cnt_r <= WIDTH'(cnt_r + 1'b1);
        end
    end

    a_done_at_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
        done && !start |-> cnt_r == limit)
        else $error("dead band ended before the count reached the limit");

    a_abort_no_done: assert property (@(posedge ref_clk) disable iff (!rst_n)
        abort && !start |=> !done || start)
        else $error("dead band completed although the input level was lost");

endmodule
`default_nettype wire

// File: verif/cdw_gate_drv.sv
// gate driver model at the two output pins
`timescale 1ns/10ps
`default_nettype none
module cdw_gate_drv (
    input  wire logic pin_a,
    input  wire logic pin_a_oe_n,
    input  wire logic pin_b,
    input  wire logic pin_b_oe_n,
    output logic      gate_a,
    output logic      gate_b
);
    // a released pin falls to the pull-down level
    assign gate_a = pin_a_oe_n ? 1'b0 : pin_a;
    assign gate_b = pin_b_oe_n ? 1'b0 : pin_b;
endmodule
`default_nettype wire

// File: verif/tb_cdw_generator.sv
// self-checking bench of the complementary waveform generator
`timescale 1ns/10ps
`default_nettype none
module tb_cdw_generator;
    import cdw_pkg::*;
    logic [PWM_CH-1:0] pch = 4'h0;
    logic [SEL_W-1:0]  sel = SEL_PULSE_CHANNEL_ONE;
    logic [DB_W-1:0]   dbr = 6'h00;
    logic [DB_W-1:0]   dbf = 6'h00;
    logic [OVR_W-1:0]  ova = OVR_INACT;
    logic [OVR_W-1:0]  ovb = OVR_INACT;
    logic ref_clk = 1'b0, rst_n = 1'b0, nco = 1'b0, lc1 = 1'b0;
    logic lc2 = 1'b0, flt = 1'b0, en = 1'b0, oea = 1'b1, oeb = 1'b1;
    logic pola = 1'b1, polb = 1'b1, cs = 1'b0, sset = 1'b0, sclr = 1'b0;
    logic ar = 1'b0, ss0 = 1'b0, ss1 = 1'b0;
    logic oa, oa_n, ob, ob_n, evt, act, ga, gb;
    logic [OVR_W-1:0] ovx[4] = '{OVR_HIGH, OVR_LOW, OVR_TRI, OVR_INACT};
    logic [7:0] ea[4] = '{8'h01, 8'h00, 8'h02, 8'h01};
    logic [7:0] eb[4] = '{8'h01, 8'h00, 8'h02, 8'h00};
    int nv[6] = '{0, 1, 5, 63, 2, 0};
    int mv[6] = '{63, 0, 1, 3, 0, 7};
    int bad_count = 0;
    int checked = 0;
    int t0, t1;

    cdw_generator dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .pulse_channel(pch),
        .numeric_oscillator_output(nco), .logic_cell1_output(lc1),
        .logic_cell2_output(lc2), .fault_input_pin(flt),
        .module_enable_bit(en), .output_a_enable(oea),
        .output_b_enable(oeb), .output_a_polarity(pola),
        .output_b_polarity(polb), .clock_source_bit(cs),
        .input_source_select(sel), .rising_deadband_register(dbr),
        .falling_deadband_register(dbf), .shutdown_event_set(sset),
        .shutdown_event_clear(sclr), .auto_restart_enable(ar),
        .shutdown_source_select_0(ss0), .shutdown_source_select_1(ss1),
        .override_level_a(ova), .override_level_b(ovb),
        .output_a(oa), .output_a_oe_n(oa_n), .output_b(ob),
        .output_b_oe_n(ob_n), .shutdown_event_bit(evt),
        .shutdown_active(act)
    );

    cdw_gate_drv drv (
        .pin_a(oa), .pin_a_oe_n(oa_n), .pin_b(ob), .pin_b_oe_n(ob_n),
        .gate_a(ga), .gate_b(gb)
    );

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic drive_src(input logic [SEL_W-1:0] code, input logic lvl);
        case (code)
            SEL_LC1: lc1 = lvl;
            SEL_NCO: nco = lvl;
            default: pch[code - 3'h2] = lvl;
        endcase
    endtask

    // edges until the leaving output is off and the arriving one is on
    task automatic watch(input int lim, input logic rise, output int t_off,
                         output int t_on);
        t_off = 0;
        t_on = 0;
        for (int i = 1; i <= lim; i++) begin
            tick(1);
            if (t_off == 0 && (rise ? ob : oa) === 1'b0) t_off = i;
            if (t_on == 0 && (rise ? oa : ob) === 1'b1) t_on = i;
        end
    endtask

    task automatic warm;
        drive_src(sel, 1'b1);
        tick(14);
        drive_src(sel, 1'b0);
        tick(14);
    endtask

    task automatic edge_pair(input int n, input int m);
        dbr = DB_W'(n);
        dbf = DB_W'(m);
        tick(2);
        drive_src(sel, 1'b1);
        watch(80, 1'b1, t0, t1);
        check("b_off", 8'(t0), 8'h04);
        check("a_on", 8'(t1), 8'(n == 0 ? 4 : n + 5));
        drive_src(sel, 1'b0);
        watch(80, 1'b0, t0, t1);
        check("a_off", 8'(t0), 8'h04);
        check("b_on", 8'(t1), 8'(m == 0 ? 4 : m + 5));
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        #1;
        check("rst", {2'h0, oa, oa_n, ob, ob_n, evt, act}, 8'h14);
        rst_n = 1'b1;
        en = 1'b1;
        warm();
        foreach (nv[i]) begin
            sel = SEL_W'(i + 2);
            edge_pair(nv[i], mv[i]);
        end
        for (int c = 0; c < 2; c++) begin
            sel = SEL_W'(c);
            tick(3);
            pch = 4'hF;
            {nco, lc1} = 2'h3;
            tick(10);
            check("rsv", {6'h0, oa, ob}, 8'h01);
            pch = 4'h0;
            {nco, lc1} = 2'h0;
            tick(10);
        end
        sel = SEL_PULSE_CHANNEL_ONE;
        dbr = 6'h0A;
        tick(3);
        pch[0] = 1'b1;
        tick(3);
        pch[0] = 1'b0;
        t0 = 0;
        repeat (30) begin
            tick(1);
            if (oa !== 1'b0) t0 = 1;
        end
        check("short", {7'h0, t0[0]}, 8'h00);
        check("b_back", {7'h0, ob}, 8'h01);
        {pola, polb} = 2'h0;
        tick(3);
        check("pol", {6'h0, oa, ob}, 8'h02);
        {pola, polb} = 2'h3;
        oea = 1'b0;
        tick(2);
        check("oe_a", {6'h0, oa_n, ga}, 8'h02);
        check("oe_b", {6'h0, ob_n, gb}, 8'h01);
        oea = 1'b1;
        en = 1'b0;
        tick(2);
        check("en_off", {6'h0, oa_n, ob_n}, 8'h03);
        en = 1'b1;
        tick(2);
        check("en_on", {6'h0, oa, ob}, 8'h00);
        warm();
        pola = 1'b0;
        dbr = 6'h02;
        sset = 1'b1;
        tick(1);
        sset = 1'b0;
        check("sw_set", {7'h0, evt}, 8'h01);
        foreach (ovx[k]) begin
            ova = ovx[k];
            ovb = ovx[k];
            tick(2);
            check("ovr_a", {6'h0, oa_n, ga}, ea[k]);
            check("ovr_b", {6'h0, ob_n, gb}, eb[k]);
        end
        pola = 1'b1;
        tick(10);
        check("sw_hold", {6'h0, evt, act}, 8'h03);
        sclr = 1'b1;
        tick(1);
        sclr = 1'b0;
        check("sw_clr", {6'h0, evt, act}, 8'h01);
        pch[0] = 1'b1;
        watch(40, 1'b1, t0, t1);
        check("resume", {7'h0, act}, 8'h00);
        check("res_a", 8'(t1), 8'h07);
        pch[0] = 1'b0;
        tick(14);
        {ar, ss0, flt} = 3'h7;
        tick(6);
        check("unsel", {7'h0, act}, 8'h00);
        flt = 1'b0;
        lc2 = 1'b1;
        tick(3);
        check("ext_in", {6'h0, evt, act}, 8'h03);
        tick(20);
        check("ext_hold", {7'h0, evt}, 8'h01);
        lc2 = 1'b0;
        tick(6);
        check("auto_clr", {6'h0, evt, act}, 8'h01);
        pch[0] = 1'b1;
        tick(8);
        check("auto_run", {7'h0, act}, 8'h00);
        pch[0] = 1'b0;
        tick(14);
        {ss0, ss1, flt} = 3'h3;
        tick(3);
        check("flt_in", {7'h0, act}, 8'h01);
        flt = 1'b0;
        tick(6);
        warm();
        cs = 1'b1;
        dbr = 6'h04;
        tick(2);
        pch[0] = 1'b1;
        watch(120, 1'b1, t0, t1);
        check("osc_off", 8'(t0), 8'h04);
        t1 = t1 - t0;
        check("osc_db", 8'(t1 >= 19 && t1 <= 30), 8'h01);
        complete_run();
    end

    initial begin
        #100000;
        bad_count++;
        complete_run();
    end
endmodule
`default_nettype wire
